// file: dv/adc_sample_clock_divider_delay_bench.sv
// Self-checking bench for the sample clock divider and its delay controls
`timescale 1ns/100ps
`default_nettype none
module adc_sample_clock_divider_delay_bench;
   typedef struct {int due; int id; logic [11:0] v;} note_s;
   logic               mclk, rst, sync_in, reg_wr, samp_clk_q, samp_strobe_q, dp_reset_q;
   logic        [11:0] reg_addr;
   logic        [11:0] regs [6];
   logic        [7:0]  reg_wdata, reg_rdata_q, fine_code_a_q, fine_code_b_q, d, c;
   logic        [7:0]  codes [4];
   logic        [1:0]  chan_sel, half_dly_q, fine_en_q, s;
   logic        [2:0]  p;
   logic signed [11:0] fine_shift_a_q, fine_shift_b_q;
   int                 failures, check_count, cyc, base, ph, nd;
   note_s              notes [$];

   clk_ctrl u_clk_ctrl (.mclk(mclk), .rst(rst), .sync_in(sync_in), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .chan_sel(chan_sel),
      .reg_rdata_q(reg_rdata_q), .samp_clk_q(samp_clk_q), .samp_strobe_q(samp_strobe_q),
      .half_dly_q(half_dly_q), .fine_en_q(fine_en_q), .fine_code_a_q(fine_code_a_q),
      .fine_code_b_q(fine_code_b_q), .fine_shift_a_q(fine_shift_a_q),
      .fine_shift_b_q(fine_shift_b_q), .dp_reset_q(dp_reset_q));
   sync_src u_sync_src (.mclk(mclk), .sync_in(sync_in));

   // 25 MHz clock and a cycle count that dates every note
   always #20 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   // Output selected by a note
   function automatic logic [11:0] obs(input int id);
      case (id)
         0: obs = {4'h0, reg_rdata_q};
         1: obs = {11'h000, samp_clk_q};
         2: obs = {11'h000, samp_strobe_q};
         3: obs = {10'h000, half_dly_q};
         4: obs = {10'h000, fine_en_q};
         5: obs = {4'h0, fine_code_a_q};
         6: obs = {4'h0, fine_code_b_q};
         7: obs = fine_shift_a_q;
         8: obs = fine_shift_b_q;
         default: obs = {11'h000, dp_reset_q};
      endcase
   endfunction : obs

   // Expected shift in tenths of a picosecond, saturating at both ends
   function automatic logic [11:0] shift_of(input logic [7:0] k);
      int e;
      e = ((k > 8'hB2) ? 178 : int'(k)) * 17 - 1517;
      shift_of = (e > 1500) ? 12'h5DC : e[11:0];
   endfunction : shift_of

   task automatic note(input int id, input logic [11:0] v, input int due);
      notes.push_back('{due, id, v});
   endtask : note

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Notes are queued in due order, so only the head can be ripe
   always @(negedge mclk) begin
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         check(obs(notes[0].id), notes[0].v); // Oldest note against the live output
         void'(notes.pop_front());
      end
   end

   // One write; the idle cycle after it keeps the strobe from being set twice in a step
   task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] cs);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = v;
      chan_sel  = cs;
      @(negedge mclk);
      reg_wr = 1'b0;
      @(negedge mclk);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [1:0] cs, input logic [7:0] exp);
      reg_addr = a;
      chan_sel = cs;
      note(0, {4'h0, exp}, cyc + 1);
      @(negedge mclk);
   endtask : rd

   // Divided clock high over the first half of the count, strobe at count zero
   task automatic clk_run(input int n);
      for (int j = 1; j <= n; j++) begin
         int k;
         k = (ph + cyc + j - base) % nd;
         note(1, {11'h000, k <= (nd - 1) / 2}, cyc + j);
         note(2, {11'h000, k == 0}, cyc + j);
      end
      repeat (n) @(negedge mclk);
   endtask : clk_run

   task automatic end_sim();
      if (failures == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   // Sequence takes about 176 cycles; a margin of over fifteen times still cuts a hang short
   initial begin
      repeat (3000) @(posedge mclk);
      failures++;
      end_sim();
   end

   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      chan_sel = 2'h0;
      {failures, check_count, cyc, base, ph, nd} = '0;
      regs = '{clk_div_pkg::ADDR_DIV_RATIO, clk_div_pkg::ADDR_HALF_DLY,
               clk_div_pkg::ADDR_SYNC_CTRL, clk_div_pkg::ADDR_FINE_EN,
               clk_div_pkg::ADDR_FINE_VAL, 12'h10E};
      void'($urandom(32'h44517856));
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      // Reset values, unmapped address included
      foreach (regs[i]) rd(regs[i], 2'b01, clk_div_pkg::CFG_RESET);
      // Read-write registers and an ignored unmapped write
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom());
         if (i == 1) note(3, {10'h000, d[1:0]}, cyc + 1);
         wr(regs[(i < 3) ? i : 5], d, 2'b01);
         rd(regs[(i < 3) ? i : 5], 2'b01, (i < 3) ? d : 8'h00);
      end
      // Every ratio, aligned by an enabled sync to a random phase
      for (int r = 0; r < 4; r++) begin
         p  = 3'($urandom());
         nd = 1 << r;
         wr(clk_div_pkg::ADDR_SYNC_CTRL, {5'h10, p}, 2'b01);
         wr(clk_div_pkg::ADDR_DIV_RATIO, 8'(r), 2'b01);
         // Pin edge, two synchroniser stages and the load pulse: phase shows four edges on
         base = cyc + 4;
         ph   = p % nd;
         u_sync_src.pulse();
         clk_run(2 * nd + 2);
      end
      // Sync with realignment off leaves the count running on
      wr(clk_div_pkg::ADDR_SYNC_CTRL, {5'h00, ~p}, 2'b01);
      u_sync_src.pulse();
      clk_run(16);
      // Fine delay per channel over boundary and random codes
      codes = '{8'h00, 8'hB2, 8'hFF, 8'($urandom())};
      for (int i = 0; i < 4; i++) begin
         c = codes[i];
         s = (i == 2) ? 2'b11 : ((i == 1) ? 2'b10 : 2'b01);
         note(4, 12'h000, cyc + 1);
         note(9, 12'h000, cyc + 1);
         wr(clk_div_pkg::ADDR_FINE_EN, 8'h00, 2'b11);
         note(5, {4'h0, c}, cyc + 1);
         note(6, {4'h0, c}, cyc + 1);
         note(7, 12'h000, cyc + 1);
         note(8, 12'h000, cyc + 1);
         wr(clk_div_pkg::ADDR_FINE_VAL, c, 2'b11);
         note(4, {10'h000, s}, cyc + 1);
         note(7, s[0] ? shift_of(c) : 12'h000, cyc + 1);
         note(8, s[1] ? shift_of(c) : 12'h000, cyc + 1);
         note(9, 12'h001, cyc + 1);
         note(9, 12'h000, cyc + 2);
         wr(clk_div_pkg::ADDR_FINE_EN, 8'h01, s);
         // Rewrite one channel only, alternating which, so neither may leak
         s = i[0] ? 2'b01 : 2'b10;
         note(5, {4'h0, s[0] ? c ^ 8'h5A : c}, cyc + 1);
         note(6, {4'h0, s[1] ? c ^ 8'h5A : c}, cyc + 1);
         wr(clk_div_pkg::ADDR_FINE_VAL, c ^ 8'h5A, s);
         rd(clk_div_pkg::ADDR_FINE_VAL, 2'b01, s[0] ? c ^ 8'h5A : c);
         rd(clk_div_pkg::ADDR_FINE_VAL, 2'b10, s[1] ? c ^ 8'h5A : c);
      end
      repeat (3) @(negedge mclk);
      end_sim();
   end
endmodule : adc_sample_clock_divider_delay_bench
`default_nettype wire

// file: dv/sync_src.sv
// Multichip sync driver standing in for the far-side timing source
`timescale 1ns/100ps
`default_nettype none
module sync_src (
   // Clock
   input  wire logic mclk,
   // Sync pin
   output logic      sync_in
);
   // Idle low so no stray edge reaches the divider
   initial sync_in = 1'b0;

   // One event, called at a falling edge; three cycles each way beats the two-cycle minimum
   task automatic pulse();
      sync_in = 1'b1;
      repeat (3) @(negedge mclk);
      sync_in = 1'b0;
      repeat (3) @(negedge mclk);
   endtask : pulse
endmodule : sync_src
`default_nettype wire

// file: hw/clk_ctrl.sv
// Sample clock control: divider registers, multichip sync, half-period and fine delay
// How it works
// - Input clock divided by one, two, four or eight per ratio register.
// - A valid sync edge loads the divider with a programmed phase.
// - Sync realignment acts only while sync control bit seven is set.
// - Half input period delay enabled per channel from its register.
// - Fine delay applies only while enable bit zero is set per channel.
// - Fine delay amount is an eight-bit value held per channel.
// - Code maps to about -151.7 to +150 ps in 1.7 ps steps.
// - Fine delay takes effect right after the enabling write.
// - Writing the fine enable bit set pulses a datapath reset.
// - Divided clock has fifty percent duty cycle, except at divide-by-one where it stays high.
// - Samples are taken on the divided clock's rising edge.
`timescale 1ns/100ps
`default_nettype none
module clk_ctrl (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               rst,
   // Multichip sync pin
   input  wire logic               sync_in,
   // Register port of the serial control interface
   input  wire logic               reg_wr,
   input  wire logic [11:0]        reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic [1:0]         chan_sel,
   output logic      [7:0]         reg_rdata_q,
   // Internal sample clock
   output logic                    samp_clk_q,
   output logic                    samp_strobe_q,
   // Per-channel delay controls and the shared datapath reset pulse
   output logic      [1:0]         half_dly_q,
   output logic      [1:0]         fine_en_q,
   output logic      [7:0]         fine_code_a_q,
   output logic      [7:0]         fine_code_b_q,
   output logic signed [11:0]      fine_shift_a_q,
   output logic signed [11:0]      fine_shift_b_q,
   output logic                    dp_reset_q
);

   typedef struct packed {
      logic [7:0]              ratio;
      logic [7:0]              half;
      logic [7:0]              syncc;
      logic [1:0][7:0]         fen;
      logic [1:0][7:0]         fval;
      logic [1:0][11:0]        fshift;
      logic [1:0]              sync_ff;
      logic                    sync_prev;
      logic                    load;
      logic                    dp_rst;
      logic [7:0]              rdata;
   } ctrl_s;

   ctrl_s s_q;
   ctrl_s s_d;
   logic  sync_rise;
   int    rd_ch;

   div_if bus ();

   div_core u_core (
      .mclk (mclk),
      .rst  (rst),
      .bus  (bus)
   );

   // Divider steering comes straight from registers
   assign bus.ratio_sel = s_q.ratio[clk_div_pkg::RATIO_W-1:0];
   assign bus.load      = s_q.load;
   assign bus.load_val  = s_q.syncc[clk_div_pkg::SYNC_STATE_LSB +: clk_div_pkg::SYNC_STATE_W];

   // Edge taken from the second synchroniser stage only
   assign sync_rise = s_q.sync_ff[1] & ~s_q.sync_prev;
   assign rd_ch     = chan_sel[0] ? 0 : 1;

   // Register writes, sync capture and delay decoding
   always_comb begin
      s_d           = s_q;
      s_d.sync_ff   = {s_q.sync_ff[0], sync_in};
      s_d.sync_prev = s_q.sync_ff[1];
      s_d.load      = sync_rise & s_q.syncc[clk_div_pkg::SYNC_EN_BIT];
      s_d.dp_rst    = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            clk_div_pkg::ADDR_DIV_RATIO: s_d.ratio = reg_wdata;
            clk_div_pkg::ADDR_HALF_DLY:  s_d.half  = reg_wdata;
            clk_div_pkg::ADDR_SYNC_CTRL: s_d.syncc = reg_wdata;
            clk_div_pkg::ADDR_FINE_EN: begin
               for (int ch = 0; ch < clk_div_pkg::NUM_CH; ch++) begin
                  if (chan_sel[ch]) begin
                     s_d.fen[ch] = reg_wdata;
                  end
               end
               // Enabling the delay disturbs the pipeline, so restart it
               s_d.dp_rst = reg_wdata[clk_div_pkg::FINE_EN_BIT] & (|chan_sel);
            end
            clk_div_pkg::ADDR_FINE_VAL: begin
               for (int ch = 0; ch < clk_div_pkg::NUM_CH; ch++) begin
                  if (chan_sel[ch]) begin
                     s_d.fval[ch] = reg_wdata;
                  end
               end
            end
            default: ;
         endcase
      end
      // Decoded from the next values so the shift follows the write at once
      for (int ch = 0; ch < clk_div_pkg::NUM_CH; ch++) begin
         s_d.fshift[ch] = s_d.fen[ch][clk_div_pkg::FINE_EN_BIT] ?
                          clk_div_pkg::fine_map(s_d.fval[ch]) : 12'h000;
      end
      // Read mux; channel registers return the lowest selected channel
      case (reg_addr)
         clk_div_pkg::ADDR_DIV_RATIO: s_d.rdata = s_q.ratio;
         clk_div_pkg::ADDR_HALF_DLY:  s_d.rdata = s_q.half;
         clk_div_pkg::ADDR_SYNC_CTRL: s_d.rdata = s_q.syncc;
         clk_div_pkg::ADDR_FINE_EN:   s_d.rdata = s_q.fen[rd_ch];
         clk_div_pkg::ADDR_FINE_VAL:  s_d.rdata = s_q.fval[rd_ch];
         default:                     s_d.rdata = 8'h00;
      endcase
   end

   // All configuration resets to the common reset value
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
         s_q.ratio <= clk_div_pkg::CFG_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs, each taken from a flip-flop
   assign reg_rdata_q    = s_q.rdata;
   assign samp_clk_q     = bus.clk;
   assign samp_strobe_q  = bus.tick;
   assign half_dly_q     = s_q.half[1:0];
   assign fine_en_q      = {s_q.fen[1][0], s_q.fen[0][0]};
   assign fine_code_a_q  = s_q.fval[0];
   assign fine_code_b_q  = s_q.fval[1];
   assign fine_shift_a_q = s_q.fshift[0];
   assign fine_shift_b_q = s_q.fshift[1];
   assign dp_reset_q     = s_q.dp_rst;

   property p_sync_load;
      @(posedge mclk) disable iff (rst)
      (sync_rise && s_q.syncc[7]) |=> bus.load ##1 (bus.cnt == ($past(s_q.syncc[2:0]) &
         clk_div_pkg::ratio_mask(bus.ratio_sel)));
   endproperty
   a_sync_load: assert property (p_sync_load) else $error("sync did not load divider phase");

   property p_sync_off;
      @(posedge mclk) disable iff (rst)
      !s_q.syncc[7] |=> !bus.load;
   endproperty
   a_sync_off: assert property (p_sync_off) else $error("sync acted while disabled");

   property p_sync_delay;
      @(posedge mclk) disable iff (rst)
      ($rose(sync_in) && s_q.syncc[7] && !reg_wr) ##1 (sync_in && !reg_wr) ##1 sync_in
         |=> bus.load;
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sync edge lost in synchroniser");

   property p_half;
      @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == clk_div_pkg::ADDR_HALF_DLY) |=> half_dly_q == $past(reg_wdata[1:0]);
   endproperty
   a_half: assert property (p_half) else $error("half-period delay select not updated");

   property p_fine_now;
      @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == clk_div_pkg::ADDR_FINE_EN && chan_sel[0])
         |=> fine_en_q[0] == $past(reg_wdata[0]) && (fine_en_q[0] || fine_shift_a_q == 12'h000);
   endproperty
   a_fine_now: assert property (p_fine_now) else $error("fine delay not applied at once");

   property p_fine_indep;
      @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == clk_div_pkg::ADDR_FINE_VAL && chan_sel == 2'h1)
         |=> fine_code_b_q == $past(fine_code_b_q) && fine_code_a_q == $past(reg_wdata);
   endproperty
   a_fine_indep: assert property (p_fine_indep) else $error("fine value leaked across channels");

   property p_fine_range;
      @(posedge mclk) disable iff (rst)
      fine_en_q[0] |-> (fine_shift_a_q >= -12'sd1517) && (fine_shift_a_q <= 12'sd1500) &&
         (fine_code_a_q != 8'h00 || fine_shift_a_q == -12'sd1517);
   endproperty
   a_fine_range: assert property (p_fine_range) else $error("fine shift out of span");

   property p_dp_reset;
      @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == clk_div_pkg::ADDR_FINE_EN && reg_wdata[0] && chan_sel != 2'h0)
         |=> dp_reset_q ##1 (!dp_reset_q || $past(reg_wr));
   endproperty
   a_dp_reset: assert property (p_dp_reset) else $error("datapath reset pulse missing");

   // No datapath restart unless a fine enable write sets bit zero
   property p_dp_quiet;
      @(posedge mclk) disable iff (rst)
      !(reg_wr && reg_addr == clk_div_pkg::ADDR_FINE_EN && reg_wdata[0]) |=> !dp_reset_q;
   endproperty
   a_dp_quiet: assert property (p_dp_quiet) else $error("stray datapath reset");

   // A ratio write steers the divider from the very next cycle
   property p_ratio_now;
      @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == clk_div_pkg::ADDR_DIV_RATIO)
         |=> bus.ratio_sel == $past(reg_wdata[1:0]);
   endproperty
   a_ratio_now: assert property (p_ratio_now) else $error("ratio not taken");

   // Disabled channel B must never carry a sampling shift
   property p_fine_gate_b;
      @(posedge mclk) disable iff (rst)
      !fine_en_q[1] |-> fine_shift_b_q == 12'sh000;
   endproperty
   a_fine_gate_b: assert property (p_fine_gate_b) else $error("disabled shift set");

endmodule : clk_ctrl
`default_nettype wire

// file: hw/clk_div_pkg.sv
// Constants and decode helpers shared by the sample clock divider and its control logic
package clk_div_pkg;

   // Register offsets on the serial control port
   localparam logic [11:0] ADDR_DIV_RATIO  = 12'h10B;
   localparam logic [11:0] ADDR_HALF_DLY   = 12'h10C;
   localparam logic [11:0] ADDR_SYNC_CTRL  = 12'h10D;
   localparam logic [11:0] ADDR_FINE_EN    = 12'h117;
   localparam logic [11:0] ADDR_FINE_VAL   = 12'h118;

   // Reset value of every configuration register
   localparam logic [7:0]  CFG_RESET       = 8'h00;

   // Field positions
   localparam int          SYNC_EN_BIT     = 7;
   localparam int          FINE_EN_BIT     = 0;
   localparam int          SYNC_STATE_LSB  = 0;
   localparam int          SYNC_STATE_W    = 3;
   localparam int          RATIO_W         = 2;
   localparam int          NUM_CH          = 2;

   // Divider ratio codes
   localparam logic [1:0]  RATIO_DIV1      = 2'h0;
   localparam logic [1:0]  RATIO_DIV2      = 2'h1;
   localparam logic [1:0]  RATIO_DIV4      = 2'h2;
   localparam logic [1:0]  RATIO_DIV8      = 2'h3;

   // Fine delay mapping, in tenths of a picosecond
   localparam logic [7:0]         FINE_MAX_CODE = 8'hB2;
   localparam logic signed [12:0] FINE_STEP     = 13'sh0011;
   localparam logic signed [12:0] FINE_MIN      = -13'sh05ED;
   localparam logic signed [12:0] FINE_MAX      = 13'sh05DC;

   // Terminal count of the divider for a ratio code
   function automatic logic [2:0] ratio_mask(input logic [1:0] sel);
      unique case (sel)
         RATIO_DIV1: ratio_mask = 3'h0;
         RATIO_DIV2: ratio_mask = 3'h1;
         RATIO_DIV4: ratio_mask = 3'h3;
         RATIO_DIV8: ratio_mask = 3'h7;
      endcase
   endfunction : ratio_mask

   // Sampling-instant shift for a fine delay code, saturated at both ends
   function automatic logic signed [11:0] fine_map(input logic [7:0] code);
      logic [7:0]         c;
      logic signed [12:0] t;
      c = (code > FINE_MAX_CODE) ? FINE_MAX_CODE : code;
      t = $signed({5'h00, c}) * FINE_STEP + FINE_MIN;
      if (t > FINE_MAX) begin
         t = FINE_MAX;
      end
      fine_map = t[11:0];
   endfunction : fine_map

endpackage : clk_div_pkg

// file: hw/div_core.sv
// Programmable divider core producing the internal sample clock and its rising-edge strobe
`timescale 1ns/100ps
`default_nettype none
module div_core (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Control from the register block
   div_if.core       bus
);

   typedef struct packed {
      logic [2:0] cnt;
      logic       clk;
      logic       tick;
   } core_s;

   core_s      s_q;
   core_s      s_d;
   logic [2:0] mask;

   assign mask     = clk_div_pkg::ratio_mask(bus.ratio_sel);
   assign bus.clk  = s_q.clk;
   assign bus.tick = s_q.tick;
   assign bus.cnt  = s_q.cnt;

   // Count modulo the ratio; a sync load jumps to the programmed phase
   always_comb begin
      s_d = s_q;
      if (bus.load) begin
         s_d.cnt = bus.load_val & mask;
      end else if (s_q.cnt >= mask) begin
         s_d.cnt = 3'h0;
      end else begin
         s_d.cnt = s_q.cnt + 3'h1;
      end
      // High for the first half of every period, whatever the input duty; held high when dividing by one
      s_d.clk  = (mask == 3'h0) ? 1'b1 : (s_d.cnt <= (mask >> 1));
      // Strobe marks the rising edge where a sample is taken
      s_d.tick = (s_d.cnt == 3'h0);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   property p_wrap;
      @(posedge mclk) disable iff (rst)
      (!bus.load && s_q.cnt == mask) |=> s_q.cnt == 3'h0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("divider did not wrap at terminal count");

   property p_duty8;
      @(posedge mclk) disable iff (rst)
      (bus.ratio_sel == 2'h3 && $stable(bus.ratio_sel) && !$past(bus.load))
         |-> s_q.clk == (s_q.cnt < 3'h4);
   endproperty
   a_duty8: assert property (p_duty8) else $error("divide-by-8 clock not half high");

   // A sync load or a ratio change can start a period mid-count, so only steady running counts
   property p_edge_tick;
      @(posedge mclk) disable iff (rst)
      ($rose(s_q.clk) && mask != 3'h0 && !bus.load && !$past(bus.load) &&
         $stable(bus.ratio_sel) && bus.ratio_sel == $past(bus.ratio_sel, 2))
         |-> s_q.tick ##1 !s_q.tick;
   endproperty
   a_edge_tick: assert property (p_edge_tick) else $error("sample strobe not on rising edge");

endmodule : div_core
`default_nettype wire

// file: hw/div_if.sv
// Control and status signals between the clock control logic and the divider core
`timescale 1ns/100ps
`default_nettype none
interface div_if;
   logic [1:0] ratio_sel;
   logic       load;
   logic [2:0] load_val;
   logic       clk;
   logic       tick;
   logic [2:0] cnt;

   modport ctrl (output ratio_sel, output load, output load_val,
                 input clk, input tick, input cnt);
   modport core (input ratio_sel, input load, input load_val,
                 output clk, output tick, output cnt);
endinterface : div_if
`default_nettype wire
